// File: src/bmc_pkg.sv
// Package: constants and types for the battery monitor mode control block
package bmc_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  // Times in their own units, as documented
  localparam int unsigned CYCLE_PERIOD_S = 1;
  localparam int unsigned CELL_UPDATE_S = 1;
  localparam int unsigned BUS_OFF_S = 2;
  localparam int unsigned BUS_READY_MS = 1;
  localparam int unsigned BUS_IDLE_MS = 50;
  // Cycle counts derived from the clock rate
  localparam longint unsigned CYCLE_PERIOD_CYC = longint'(CYCLE_PERIOD_S) * CLK_HZ;
  localparam longint unsigned BUS_OFF_CYC = longint'(BUS_OFF_S) * CLK_HZ;
  localparam longint unsigned BUS_READY_CYC = longint'(BUS_READY_MS) * CLK_HZ / 1000;
  localparam longint unsigned BUS_IDLE_CYC = longint'(BUS_IDLE_MS) * CLK_HZ / 1000 + 1;
  // Charge counter resolution in picovolt-hours per count
  localparam int unsigned CHARGE_LSB_PVH = 650;

  // AXI4-Lite register byte offsets
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_SLEEP_INTERVAL = 8'h04;
  localparam logic [7:0] REG_WAKE_THRESHOLD = 8'h08;
  localparam logic [7:0] REG_CAL_LOW_TIME = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_CHARGE = 8'h14;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h18;
  localparam logic [7:0] REG_IRQ_MASK = 8'h1C;
  localparam logic [7:0] REG_CELL_V = 8'h20;
  localparam logic [7:0] REG_TEMP = 8'h24;

  // Control register fields
  localparam int unsigned CTL_SLEEP_REQ = 0;
  localparam int unsigned CTL_SHUTDOWN = 1;
  localparam int unsigned CTL_WAKE_EN = 2;
  localparam int unsigned CTL_NON_REMOVAL = 3;
  localparam int unsigned CTL_TIMEOUT_DIS = 4;
  localparam int unsigned CTL_TEMP_SEL = 5;
  localparam int unsigned CTL_FET_EN = 7;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0080;
  localparam logic [31:0] SLEEP_INTERVAL_RESET = 32'h0000_0005;
  localparam logic [31:0] WAKE_THRESHOLD_RESET = 32'h0000_0100;
  localparam logic [31:0] CAL_LOW_TIME_RESET = 32'h0000_0010;

  // Interrupt status bit positions
  localparam int unsigned IRQ_CYCLE = 0;
  localparam int unsigned IRQ_WAKE = 1;
  localparam int unsigned IRQ_REMOVED = 2;
  localparam int unsigned IRQ_BUS_OFF = 3;
  localparam int unsigned IRQ_CAL = 4;
  localparam int unsigned IRQ_ABORT = 5;
  localparam int unsigned IRQ_FAULT = 6;
  localparam int unsigned IRQ_W = 7;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Temperature source selections
  localparam logic [1:0] TSRC_INTERNAL = 2'd0;
  localparam logic [1:0] TSRC_EXT_A = 2'd1;
  localparam logic [1:0] TSRC_EXT_B = 2'd2;
  localparam logic [1:0] TSRC_EXT_AB = 2'd3;

  typedef enum logic [1:0] {BMC_NORMAL, BMC_SLEEP, BMC_SHUTDOWN, BMC_REMOVED} bmc_mode_t;
endpackage : bmc_pkg

// File: src/bmc_top.sv
// Battery monitor mode control: power modes, charge counting, bus watch, AXI4-Lite registers
`timescale 1ns/1ns
module bmc_top
  import bmc_pkg::*;
#(
  parameter int unsigned CELLS = 4,
  parameter int unsigned ADC_W = 16,
  parameter int unsigned ACC_W = 32,
  parameter longint unsigned CYCLE_CYC = CYCLE_PERIOD_CYC,
  parameter longint unsigned OFF_CYC = BUS_OFF_CYC,
  parameter longint unsigned IDLE_CYC = BUS_IDLE_CYC,
  parameter longint unsigned READY_CYC = BUS_READY_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and converter samples
  input wire logic pack_present_n,
  input wire logic bus_clock_pin,
  input wire logic bus_data_pin,
  input wire logic signed [ADC_W-1:0] sense_sample,
  input wire logic sense_valid,
  input wire logic [CELLS*ADC_W-1:0] cell_raw,
  input wire logic [ADC_W-1:0] cell_offset,
  input wire logic [ADC_W-1:0] temp_internal,
  input wire logic [ADC_W-1:0] thermistor_in_a,
  input wire logic [ADC_W-1:0] thermistor_in_b,
  input wire logic second_level_fault,
  output logic charge_fet,
  output logic discharge_fet,
  output logic zero_volt_charge_fet,
  output logic safety_fault,
  output logic measure_strobe,
  output logic charging,
  output logic discharging,
  output logic cal_start,
  output logic bus_off,
  output logic bus_ready,
  output logic bus_abort,
  output logic irq
);

  logic [31:0] control;
  logic [31:0] sleep_interval;
  logic [31:0] wake_threshold;
  logic [31:0] cal_low_time;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_event;
  bmc_mode_t mode;
  logic [63:0] tick_cnt;
  logic [31:0] sleep_cnt;
  logic signed [ACC_W-1:0] charge_acc;
  logic [ADC_W-1:0] cell_v [CELLS];
  logic [ADC_W-1:0] temp_value;
  logic [63:0] low_cnt;
  logic [63:0] high_cnt;
  logic [63:0] ready_cnt;
  logic cal_done;
  logic idle_done;
  logic wake_hit;
  logic cycle_tick;
  logic both_low;
  logic both_high;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Magnitude of a signed sample
  function automatic logic [ADC_W-1:0] abs_val(input logic signed [ADC_W-1:0] v);
    abs_val = v[ADC_W-1] ? ADC_W'(-v) : ADC_W'(v);
  endfunction : abs_val

  // Byte-lane merge for a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  assign both_low = !bus_clock_pin && !bus_data_pin;
  assign both_high = bus_clock_pin && bus_data_pin;
  assign wake_hit = control[CTL_WAKE_EN] && sense_valid &&
                    (abs_val(sense_sample) >= wake_threshold[ADC_W-1:0]);
  assign cycle_tick = (mode == BMC_NORMAL && tick_cnt == CYCLE_CYC - 1) ||
                      (mode == BMC_SLEEP && tick_cnt == CYCLE_CYC - 1 &&
                       sleep_cnt + 32'h0000_0001 >= sleep_interval);
  assign cal_done = both_low && low_cnt + 64'd1 == {32'h0000_0000, cal_low_time} * CYCLE_CYC;
  assign idle_done = both_high && high_cnt + 64'd1 == IDLE_CYC;

  // Power mode sequencer
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode <= BMC_NORMAL;
    end else if (control[CTL_SHUTDOWN]) begin
      mode <= BMC_SHUTDOWN;
    end else if (pack_present_n && !control[CTL_NON_REMOVAL]) begin
      mode <= BMC_REMOVED;
    end else begin
      unique case (mode)
        BMC_NORMAL: mode <= control[CTL_SLEEP_REQ] ? BMC_SLEEP : BMC_NORMAL;
        BMC_SLEEP: begin
          if (second_level_fault || wake_hit || !control[CTL_SLEEP_REQ]) begin
            mode <= BMC_NORMAL;
          end
        end
        BMC_SHUTDOWN: mode <= BMC_NORMAL;
        BMC_REMOVED: mode <= BMC_NORMAL;
      endcase
    end
  end

  // Second counter and sleep interval counter
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt <= 64'd0;
      sleep_cnt <= 32'h0000_0000;
    end else if (mode == BMC_SHUTDOWN) begin
      tick_cnt <= 64'd0;
      sleep_cnt <= 32'h0000_0000;
    end else if (tick_cnt == CYCLE_CYC - 1) begin
      tick_cnt <= 64'd0;
      if (mode != BMC_SLEEP || cycle_tick) begin
        sleep_cnt <= 32'h0000_0000;
      end else begin
        sleep_cnt <= sleep_cnt + 32'h0000_0001;
      end
    end else begin
      tick_cnt <= tick_cnt + 64'd1;
    end
  end

  // Measurement strobe, one pulse per active cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      measure_strobe <= 1'b0;
    end else begin
      measure_strobe <= cycle_tick;
    end
  end

  // Charge direction and accumulator
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      charge_acc <= '0;
      charging <= 1'b0;
      discharging <= 1'b0;
    end else if (mode == BMC_SHUTDOWN) begin
      charging <= 1'b0;
      discharging <= 1'b0;
    end else if (sense_valid) begin
      charging <= !sense_sample[ADC_W-1] && sense_sample != '0;
      discharging <= sense_sample[ADC_W-1];
      charge_acc <= charge_acc + ACC_W'(sense_sample);
    end
  end

  // Cell voltage and temperature refresh on each cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < CELLS; i++) begin
        cell_v[i] <= '0;
      end
      temp_value <= '0;
    end else if (cycle_tick) begin
      for (int i = 0; i < CELLS; i++) begin
        cell_v[i] <= cell_raw[i*ADC_W +: ADC_W] - cell_offset;
      end
      unique case (control[CTL_TEMP_SEL +: 2])
        TSRC_INTERNAL: temp_value <= temp_internal;
        TSRC_EXT_A: temp_value <= thermistor_in_a;
        TSRC_EXT_B: temp_value <= thermistor_in_b;
        TSRC_EXT_AB: temp_value <= (thermistor_in_a > thermistor_in_b) ? thermistor_in_a :
                                   thermistor_in_b;
      endcase
    end
  end

  // FET drives and fault output
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      charge_fet <= 1'b0;
      discharge_fet <= 1'b0;
      zero_volt_charge_fet <= 1'b0;
      safety_fault <= 1'b0;
    end else begin
      charge_fet <= mode == BMC_NORMAL && control[CTL_FET_EN];
      discharge_fet <= mode == BMC_NORMAL && control[CTL_FET_EN];
      zero_volt_charge_fet <= mode == BMC_NORMAL && control[CTL_FET_EN];
      safety_fault <= second_level_fault && mode != BMC_SHUTDOWN;
    end
  end

  // Bus-low timer, bus-off and calibration trigger
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt <= 64'd0;
      bus_off <= 1'b0;
      cal_start <= 1'b0;
    end else begin
      cal_start <= cal_done;
      if (!both_low) begin
        low_cnt <= 64'd0;
        bus_off <= 1'b0;
      end else begin
        if (low_cnt != 64'hFFFF_FFFF_FFFF_FFFF) begin
          low_cnt <= low_cnt + 64'd1;
        end
        if (low_cnt + 64'd1 >= OFF_CYC) begin
          bus_off <= 1'b1;
        end
      end
    end
  end

  // Bus ready after bus-off, and idle abort
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ready_cnt <= 64'd0;
      bus_ready <= 1'b1;
      high_cnt <= 64'd0;
      bus_abort <= 1'b0;
    end else begin
      if (bus_off) begin
        ready_cnt <= 64'd0;
        bus_ready <= 1'b0;
      end else if (!bus_ready) begin
        ready_cnt <= ready_cnt + 64'd1;
        bus_ready <= ready_cnt + 64'd1 >= READY_CYC;
      end
      high_cnt <= both_high ? high_cnt + 64'd1 : 64'd0;
      bus_abort <= idle_done && !control[CTL_TIMEOUT_DIS];
    end
  end

  // Interrupt events
  always_comb begin
    irq_event = '0;
    irq_event[IRQ_CYCLE] = cycle_tick;
    irq_event[IRQ_WAKE] = mode == BMC_SLEEP && (wake_hit || second_level_fault);
    irq_event[IRQ_REMOVED] = mode != BMC_REMOVED && pack_present_n &&
                             !control[CTL_NON_REMOVAL];
    irq_event[IRQ_BUS_OFF] = both_low && low_cnt + 64'd1 == OFF_CYC;
    irq_event[IRQ_CAL] = cal_done;
    irq_event[IRQ_ABORT] = idle_done && !control[CTL_TIMEOUT_DIS];
    irq_event[IRQ_FAULT] = second_level_fault && !safety_fault;
  end

  // AXI4-Lite write channel capture
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr[1:0] == 2'b00 && aw_addr <= REG_TEMP) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1; // Both channels reopen once the response is taken
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Register writes and sticky interrupt status; set wins over clear
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      control <= CONTROL_RESET;
      sleep_interval <= SLEEP_INTERVAL_RESET;
      wake_threshold <= WAKE_THRESHOLD_RESET;
      cal_low_time <= CAL_LOW_TIME_RESET;
      irq_mask <= '0;
      irq_status <= '0;
    end else begin
      if (aw_held && w_held && !s_axi_bvalid) begin
        unique case (aw_addr)
          REG_CONTROL: control <= merge(control, w_data, w_strb);
          REG_SLEEP_INTERVAL: sleep_interval <= merge(sleep_interval, w_data, w_strb);
          REG_WAKE_THRESHOLD: wake_threshold <= merge(wake_threshold, w_data, w_strb);
          REG_CAL_LOW_TIME: cal_low_time <= merge(cal_low_time, w_data, w_strb);
          REG_IRQ_MASK: irq_mask <= w_strb[0] ? w_data[IRQ_W-1:0] : irq_mask;
          default: ;
        endcase
      end
      if (aw_held && w_held && !s_axi_bvalid && aw_addr == REG_IRQ_STATUS && w_strb[0]) begin
        irq_status <= (irq_status & ~w_data[IRQ_W-1:0]) | irq_event;
      end else begin
        irq_status <= irq_status | irq_event;
      end
    end
  end

  // Interrupt output
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        REG_CONTROL: s_axi_rdata <= control;
        REG_SLEEP_INTERVAL: s_axi_rdata <= sleep_interval;
        REG_WAKE_THRESHOLD: s_axi_rdata <= wake_threshold;
        REG_CAL_LOW_TIME: s_axi_rdata <= cal_low_time;
        REG_STATUS: s_axi_rdata <= {24'h00_0000, bus_ready, bus_off, discharging, charging,
                                    safety_fault, charge_fet, mode};
        REG_CHARGE: s_axi_rdata <= 32'(charge_acc);
        REG_IRQ_STATUS: s_axi_rdata <= {25'h000_0000, irq_status};
        REG_IRQ_MASK: s_axi_rdata <= {25'h000_0000, irq_mask};
        REG_CELL_V: s_axi_rdata <= {cell_v[1], cell_v[0]};
        REG_TEMP: s_axi_rdata <= {16'h0000, temp_value};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : bmc_top

// File: tb/bmc_host_model.sv
// Host side model: drives the two bus lines of the pack interface
`timescale 1ns/1ns
module bmc_host_model (
  input wire logic hold_low,
  input wire logic rel_data,
  output logic bus_clock_pin,
  output logic bus_data_pin
);
  // Lines idle high by pull-up; hold_low forces both low, rel_data forces clock low alone
  assign bus_clock_pin = !(hold_low || rel_data);
  assign bus_data_pin = !hold_low;
endmodule : bmc_host_model

// File: tb/bmc_top_sva.sv
// Checker: timing of bus watch, fault, sense and strobe outputs
`timescale 1ns/1ns
module bmc_top_sva #(
  parameter int unsigned ADC_W = 16,
  parameter longint unsigned CYCLE_CYC = 100,
  parameter longint unsigned OFF_CYC = 200,
  parameter longint unsigned IDLE_CYC = 50,
  parameter longint unsigned READY_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic bus_clock_pin,
  input wire logic bus_data_pin,
  input wire logic signed [ADC_W-1:0] sense_sample,
  input wire logic sense_valid,
  input wire logic second_level_fault,
  input logic safety_fault,
  input logic measure_strobe,
  input logic charging,
  input logic discharging,
  input logic cal_start,
  input logic bus_off,
  input logic bus_ready,
  input logic bus_abort
);
  localparam int OFF_LO = int'(OFF_CYC) - 3;
  localparam int OFF_HI = int'(OFF_CYC) + 3;
  localparam int IDL_LO = int'(IDLE_CYC) - 3;
  localparam int IDL_HI = int'(IDLE_CYC) + 3;
  localparam int CAL_LO = int'(CYCLE_CYC) - 3;
  localparam int RDY = int'(READY_CYC) + 4;
  int lo;
  int hi;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Run lengths of both-low and both-high line samples
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lo <= 0;
      hi <= 0;
    end else begin
      lo <= (!bus_clock_pin && !bus_data_pin) ? lo + 1 : 0;
      hi <= (bus_clock_pin && bus_data_pin) ? hi + 1 : 0;
    end
  end
  property p_off_rise;
    $rose(bus_off) |-> lo >= OFF_LO && lo <= OFF_HI;
  endproperty
  a_off_rise: assert property (p_off_rise) else $error("bus off at wrong count");
  property p_off_fall;
    bus_off && (bus_clock_pin || bus_data_pin) |-> ##[1:4] !bus_off;
  endproperty
  a_off_fall: assert property (p_off_fall) else $error("bus off kept");
  property p_rdy_low;
    bus_off |=> !bus_ready;
  endproperty
  a_rdy_low: assert property (p_rdy_low) else $error("ready during bus off");
  property p_rdy_up;
    $fell(bus_off) |-> ##[1:RDY] bus_ready;
  endproperty
  a_rdy_up: assert property (p_rdy_up) else $error("ready late");
  property p_abort;
    bus_abort |-> hi >= IDL_LO && hi <= IDL_HI;
  endproperty
  a_abort: assert property (p_abort) else $error("abort at wrong idle count");
  property p_cal;
    cal_start |-> lo >= CAL_LO;
  endproperty
  a_cal: assert property (p_cal) else $error("calibration too early");
  property p_cal_pulse;
    cal_start |=> !cal_start;
  endproperty
  a_cal_pulse: assert property (p_cal_pulse) else $error("calibration pulse long");
  property p_safety;
    safety_fault |-> $past(second_level_fault);
  endproperty
  a_safety: assert property (p_safety) else $error("fault output without cause");
  property p_chg;
    sense_valid && sense_sample > 0 |=> charging && !discharging;
  endproperty
  a_chg: assert property (p_chg) else $error("positive sample not charging");
  property p_dis;
    sense_valid && sense_sample < 0 |=> discharging && !charging;
  endproperty
  a_dis: assert property (p_dis) else $error("negative sample not discharging");
  property p_strobe;
    measure_strobe |=> !measure_strobe;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe longer than a cycle");
endmodule : bmc_top_sva
bind bmc_top bmc_top_sva #(.ADC_W(ADC_W), .CYCLE_CYC(CYCLE_CYC), .OFF_CYC(OFF_CYC),
  .IDLE_CYC(IDLE_CYC), .READY_CYC(READY_CYC)) bmc_top_sva_i (.clk_sys, .arst_n,
  .bus_clock_pin, .bus_data_pin, .sense_sample, .sense_valid, .second_level_fault,
  .safety_fault, .measure_strobe, .charging, .discharging, .cal_start, .bus_off,
  .bus_ready, .bus_abort);

// File: tb/testbench.sv
// Testbench: scenarios for modes, counting and bus watch
`timescale 1ns/1ns
module testbench;
  import bmc_pkg::*;
  localparam int CY = 100, OF = 200, ID = 50, RD = 20;
  logic clk_sys = 0, arst_n = 0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, bus_clock_pin, bus_data_pin, charge_fet, discharge_fet;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic pack_present_n = 0, hold_low = 0, rel_data = 0, sense_valid = 0;
  logic signed [15:0] sense_sample = '0;
  logic second_level_fault = 0, zero_volt_charge_fet, safety_fault, measure_strobe;
  logic charging, discharging, cal_start, bus_off, bus_ready, bus_abort, irq;
  logic [63:0] cell_raw = '0;
  logic [15:0] cell_offset = 16'h0010, temp_internal = 16'h0123;
  logic [15:0] thermistor_in_a = 16'h0456, thermistor_in_b = 16'h0234;
  int miscompares = 0, n_checks = 0, n_cal = 0, n_abt = 0, n_stb = 0, c, k;
  always #4 clk_sys = ~clk_sys;
  bmc_top #(.CYCLE_CYC(CY), .OFF_CYC(OF), .IDLE_CYC(ID), .READY_CYC(RD)) bmc_top_i (
    .clk_sys, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pack_present_n, .bus_clock_pin,
    .bus_data_pin, .sense_sample, .sense_valid, .cell_raw, .cell_offset, .temp_internal,
    .thermistor_in_a, .thermistor_in_b, .second_level_fault, .charge_fet, .discharge_fet,
    .zero_volt_charge_fet, .safety_fault, .measure_strobe, .charging, .discharging,
    .cal_start, .bus_off, .bus_ready, .bus_abort, .irq);
  bmc_host_model bmc_host_model_i (.hold_low, .rel_data, .bus_clock_pin, .bus_data_pin);
  // Pulse counters for one-cycle outputs
  always @(posedge clk_sys) begin
    n_cal <= n_cal + (cal_start === 1'b1);
    n_abt <= n_abt + (bus_abort === 1'b1);
    n_stb <= n_stb + (measure_strobe === 1'b1);
  end
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt
  // Register write: address and data offered together, response awaited
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr
  task automatic smp(input logic signed [15:0] v);
    @(posedge clk_sys);
    sense_sample <= v;
    sense_valid <= 1'b1;
    @(posedge clk_sys);
    sense_valid <= 1'b0;
  endtask : smp
  // Cycles until the next measurement strobe
  task automatic wstb();
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while (measure_strobe !== 1'b1 && c < 1000);
  endtask : wstb
  task automatic t_regs;
    logic [31:0] ex [4] = '{32'h0000_0080, 32'h0000_0005, 32'h0000_0100, 32'h0000_0010};
    for (int i = 0; i < 4; i++) begin
      rdr(8'(i * 4));
      chk(rd === ex[i] && rs === RESP_OKAY, "reset value");
    end
    rdr(8'h28);
    chk(rs === RESP_SLVERR && rd === '0, "unmapped read");
    wr(8'h28, 32'h0000_0001);
    chk(rs === RESP_SLVERR, "unmapped write");
    wr(REG_STATUS, 32'h0000_0003);
    rdr(REG_STATUS);
    chk(rd[1:0] === BMC_NORMAL && charge_fet === 1'b1, "installed normal");
    $display("t_regs done");
  endtask : t_regs
  task automatic t_cycle;
    wstb();
    wstb();
    chk(c == CY, "normal period");
    wt(40);
    cell_raw <= 64'h0000_0000_0220_0110;
    rdr(REG_CELL_V);
    chk(rd === 32'hfff0_fff0, "cells early");
    wstb();
    wt(3);
    rdr(REG_CELL_V);
    chk(rd === 32'h0210_0100, "cells refresh");
    $display("t_cycle done");
  endtask : t_cycle
  task automatic t_sleep;
    wr(REG_SLEEP_INTERVAL, 32'h0000_0002);
    wr(REG_CONTROL, 32'h0000_0081);
    wr(REG_IRQ_STATUS, 32'h0000_007f);
    rdr(REG_STATUS);
    chk(rd[1:0] === BMC_SLEEP, "sleep mode");
    wstb();
    wstb();
    chk(c == 2 * CY, "sleep period");
    smp(16'hff00);
    wt(3);
    rdr(REG_IRQ_STATUS);
    chk(rd[IRQ_WAKE] === 1'b0, "wake while disabled");
    wr(REG_CONTROL, 32'h0000_0085);
    smp(16'h00f0);
    wt(3);
    rdr(REG_IRQ_STATUS);
    chk(rd[IRQ_WAKE] === 1'b0, "wake below level");
    smp(16'hff00);
    wt(3);
    rdr(REG_IRQ_STATUS);
    chk(rd[IRQ_WAKE] === 1'b1, "current wake");
    wr(REG_IRQ_STATUS, 32'h0000_007f);
    second_level_fault <= 1'b1;
    wt(3);
    chk(safety_fault === 1'b1 && irq === 1'b0, "fault masked");
    wr(REG_IRQ_MASK, 32'h0000_0040);
    wt(3);
    rdr(REG_IRQ_STATUS);
    chk(irq === 1'b1 && rd[IRQ_FAULT] === 1'b1 && rd[IRQ_WAKE] === 1'b1, "fault wake");
    second_level_fault <= 1'b0;
    wr(REG_IRQ_STATUS, 32'h0000_0040);
    wt(3);
    chk(irq === 1'b0 && safety_fault === 1'b0, "fault cleared");
    wr(REG_IRQ_MASK, 32'h0000_0000);
    wr(REG_CONTROL, 32'h0000_0080);
    $display("t_sleep done");
  endtask : t_sleep
  task automatic t_shut;
    wr(REG_CONTROL, 32'h0000_0082);
    wt(2);
    k = n_stb;
    second_level_fault <= 1'b1;
    wt(2 * CY);
    chk(n_stb == k && safety_fault === 1'b0, "shutdown idle");
    chk(charge_fet === 1'b0, "shutdown fets");
    second_level_fault <= 1'b0;
    wr(REG_CONTROL, 32'h0000_0080);
    $display("t_shut done");
  endtask : t_shut
  task automatic t_rem;
    wt(1);
    pack_present_n <= 1'b1;
    rdr(REG_STATUS);
    chk(rd[1:0] === BMC_REMOVED, "removed mode");
    chk(charge_fet === 1'b0 && discharge_fet === 1'b0, "removed fets");
    chk(zero_volt_charge_fet === 1'b0, "removed zero volt fet");
    wr(REG_CONTROL, 32'h0000_0088);
    rdr(REG_STATUS);
    chk(rd[1:0] === BMC_NORMAL && charge_fet === 1'b1, "non-removal");
    wr(REG_CONTROL, 32'h0000_0080);
    pack_present_n <= 1'b0;
    wt(4);
    chk(discharge_fet === 1'b1, "reinstalled");
    $display("t_rem done");
  endtask : t_rem
  task automatic t_chg;
    logic [31:0] q;
    rdr(REG_CHARGE);
    q = rd;
    for (int i = 0; i < 3; i++) smp(16'h0064);
    wt(1);
    chk(charging === 1'b1 && discharging === 1'b0, "charging");
    smp(16'hffe2);
    wt(1);
    chk(discharging === 1'b1 && charging === 1'b0, "discharging");
    rdr(REG_CHARGE);
    chk(rd - q === 32'h0000_010e, "charge sum");
    $display("t_chg done");
  endtask : t_chg
  task automatic t_bus;
    wr(REG_CAL_LOW_TIME, 32'h0000_0001);
    for (int s = 0; s < 2; s++) begin
      k = n_cal;
      hold_low <= 1'b1;
      wt(CY - 10);
      hold_low <= 1'b0;
      wt(1);
      hold_low <= 1'b1;
      wt(CY - 10);
      chk(n_cal == k && bus_off === 1'b0, "interrupted low");
      wt(OF);
      chk(bus_off === 1'b1 && bus_ready === 1'b0, "bus off");
      chk(n_cal == k + 1, "calibration start");
      rel_data <= s[0];
      hold_low <= 1'b0;
      wt(5);
      chk(bus_off === 1'b0, "bus off left");
      wt(RD + 4);
      chk(bus_ready === 1'b1, "bus ready");
      rel_data <= 1'b0;
    end
    $display("t_bus done");
  endtask : t_bus
  task automatic t_abort;
    for (int s = 0; s < 2; s++) begin
      wr(REG_CONTROL, s ? 32'h0000_0090 : 32'h0000_0080);
      hold_low <= 1'b1;
      wt(5);
      hold_low <= 1'b0;
      k = n_abt;
      wt(2 * ID);
      chk(n_abt - k == 1 - s, "idle abort");
    end
    wr(REG_CONTROL, 32'h0000_0080);
    $display("t_abort done");
  endtask : t_abort
  task automatic t_temp;
    logic [15:0] ex [4] = '{16'h0123, 16'h0456, 16'h0234, 16'h0456};
    for (int s = 0; s < 4; s++) begin
      wr(REG_CONTROL, 32'h0000_0080 | 32'(s << 5));
      wstb();
      wt(3);
      rdr(REG_TEMP);
      chk(rd[15:0] === ex[s], "temperature source");
    end
    $display("t_temp done");
  endtask : t_temp
  task automatic close_out;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  // Main sequence after a 16-cycle reset
  initial begin
    wt(16);
    arst_n <= 1'b1;
    t_regs();
    t_cycle();
    t_sleep();
    t_shut();
    t_rem();
    t_chg();
    t_bus();
    t_abort();
    t_temp();
    close_out();
  end
  // Watchdog against a hang
  initial begin
    wt(20000);
    miscompares++;
    $display("[FAIL] %0t watchdog", $time);
    close_out();
  end
endmodule : testbench
